// ---- line_list_pkg.sv ----
package line_list_pkg;
  localparam int ADDR_W = 19;
  localparam int STRIDE_W = 12;
  // control word bit positions, first byte in bits 7:0
  localparam int B_TEXT = 0;
  localparam int B_PIXEL = 1;
  localparam int B_OFF = 2;
  localparam int B_MAP_ON = 3;
  localparam int B_MAP_OFF = 4;
  localparam int B_REPEAT = 5;
  localparam int B_HIRES = 12;
  localparam int B_LORES = 13;
  localparam int B_TERM = 15;
  // parameter groups follow control bits 5..11 in order
  localparam logic [2:0] GRP_REPEAT = 3'h0;
  localparam logic [2:0] GRP_OV_PTR = 3'h1;
  localparam logic [2:0] GRP_TSCROLL = 3'h2;
  localparam logic [2:0] GRP_FONT = 3'h3;
  localparam logic [2:0] GRP_MAP_PTR = 3'h4;
  localparam logic [2:0] GRP_MAP_PAR = 3'h5;
  localparam logic [2:0] GRP_SPAN = 3'h6;
  localparam logic [2:0] GRP_NONE = 3'h7;
  localparam int GRP_FIRST_BIT = 5;
  // display span byte layout
  localparam int SPAN_LSB = 0;
  localparam int BANK_LSB = 4;
  // top-of-frame values and the last text row
  localparam logic [1:0] SPAN_RST = 2'h1;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [7:0] PRIO_RST = 8'hff;
  localparam logic [4:0] FIELD_RST = 5'h07;
  localparam logic [2:0] TEXT_ROW_LAST = 3'h7;
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_CW0   = 6'h02,
    S_CW1   = 6'h04,
    S_PARAM = 6'h08,
    S_READY = 6'h10,
    S_VWAIT = 6'h20
  } list_state_t;
endpackage

// ---- list_byte_fetch.sv ----
`timescale 1ns/1ps
module list_byte_fetch
  import line_list_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request from the interpreter
  input wire logic start,
  input wire logic abort,
  input wire logic [ADDR_W-1:0] addr,
  output logic busy,
  output logic done,
  output logic [7:0] data,
  // video memory read port
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  logic req_r, req_nxt, done_r, done_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;

  always_comb
  begin
    req_nxt = req_r;
    addr_nxt = addr_r;
    done_nxt = 1'b0;
    data_nxt = data_r;
    if (abort)
    begin
      req_nxt = 1'b0;
    end
    else if (req_r && mem_ack)
    begin
      req_nxt = 1'b0;
      done_nxt = 1'b1;
      data_nxt = mem_rdata;
    end
    else if (!req_r && start)
    begin
      req_nxt = 1'b1;
      addr_nxt = addr;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_r <= 1'b0;
      addr_r <= '0;
      done_r <= 1'b0;
      data_r <= 8'h00;
    end
    else
    begin
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      done_r <= done_nxt;
      data_r <= data_nxt;
    end
  end

  assign busy = req_r;
  assign done = done_r;
  assign data = data_r;
  assign mem_req = req_r;
  assign mem_addr = addr_r;
endmodule

// ---- line_list_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// - run the list from the start at frame top if list_run_enable is set then; clearing it mid-frame does not stop the list
// - start pointer from three bytes reaches all 512KB; list length has no limit
// - record is a two-byte control word plus 0 to 20 parameter bytes
// - whole record decoded before its scanline; any bit combination accepted
// - bits 1.0-1.2 text, pixel, off; several means off; none keeps; off at top
// - bits 1.3/1.4 map on/off; both means off; none keeps; off at top
// - bit 1.5 byte x; next x lines reuse settings without list fetches
// - bit 1.6 loads 19-bit overlay pointer then 12-bit stride, little endian
// - stride added each line in pixel mode, every eighth line in text mode
// - bit 1.7 loads text horizontal then vertical scroll, 0 to 7
// - text scroll always active, zero at frame top, persists until reloaded
// - bit 2.0 byte selects font base on a 2K boundary
// - bit 2.1 loads 19-bit map pointer then 12-bit map stride
// - map stride added after last line of a field row unless reloaded
// - bit 2.2 loads map hscroll, vscroll, field width and height codes
// - map scrolls zero, field codes 7 at frame top; values persist
// - bit 2.3 loads span select plus colour shift, then main priority
// - colour index uses palette bank offset 0 to 15, zero by default
// - main priority byte, default 255, ignored while the map is on
// - bit 2.4 selects high resolution only in pixel mode
// - bit 2.5 selects low resolution only in pixel mode; bit 2.6 reserved
// - bit 2.7 ends the list; wait for vertical sync then restart
module line_list_ctrl
  import line_list_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic list_run_enable,
  input wire logic [7:0] list_pointer_low,
  input wire logic [7:0] list_pointer_mid,
  input wire logic [2:0] list_pointer_high,
  // display timing, one-cycle pulses
  input wire logic vsync_pulse,
  input wire logic line_end,
  // video memory read port
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // settings towards the display pipeline
  output logic line_ready,
  output logic overlay_text,
  output logic overlay_pixel,
  output logic high_res,
  output logic low_res,
  output logic map_on,
  output logic [ADDR_W-1:0] overlay_memory_pointer,
  output logic [STRIDE_W-1:0] overlay_line_stride,
  output logic [2:0] text_hscroll,
  output logic [2:0] text_vscroll,
  output logic [7:0] font_base,
  output logic [ADDR_W-1:0] attribute_map_pointer,
  output logic [STRIDE_W-1:0] attribute_map_stride,
  output logic [4:0] map_hscroll,
  output logic [4:0] map_vscroll,
  output logic [4:0] field_width,
  output logic [4:0] field_height,
  output logic [1:0] display_span_select,
  output logic [3:0] palette_bank_offset,
  output logic [7:0] main_priority
);
  function automatic logic [2:0] grp_len(input logic [2:0] g);
    case (g)
      GRP_REPEAT: grp_len = 3'd1;
      GRP_OV_PTR: grp_len = 3'd5;
      GRP_TSCROLL: grp_len = 3'd2;
      GRP_FONT: grp_len = 3'd1;
      GRP_MAP_PTR: grp_len = 3'd5;
      GRP_MAP_PAR: grp_len = 3'd4;
      default: grp_len = 3'd2;
    endcase
  endfunction
  function automatic logic [2:0] next_grp(input logic [15:0] c, input logic [3:0] from);
    logic [2:0] res;
    res = GRP_NONE;
    for (int k = 6; k >= 0; k--)
    begin
      if (4'(k) >= from && c[GRP_FIRST_BIT + k])
        res = 3'(k);
    end
    return res;
  endfunction
  list_state_t st_r, st_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] la_r, la_nxt;
  logic [2:0] grp_r, grp_nxt, bi_r, bi_nxt;
  logic [7:0] rpt_r, rpt_nxt;
  logic [2:0] trow_r, trow_nxt;
  logic [4:0] mrow_r, mrow_nxt;
  logic otx_r, otx_nxt, opx_r, opx_nxt, hr_r, hr_nxt, lr_r, lr_nxt, map_r, map_nxt;
  logic [ADDR_W-1:0] op_r, op_nxt, mp_r, mp_nxt;
  logic [STRIDE_W-1:0] os_r, os_nxt, ms_r, ms_nxt;
  logic [2:0] ths_r, ths_nxt, tvs_r, tvs_nxt;
  logic [7:0] fb_r, fb_nxt, pr_r, pr_nxt;
  logic [4:0] mhs_r, mhs_nxt, mvs_r, mvs_nxt, fw_r, fw_nxt, fh_r, fh_nxt;
  logic [1:0] sp_r, sp_nxt;
  logic [3:0] bk_r, bk_nxt;
  logic f_busy, f_done, f_start;
  logic [7:0] f_data;
  logic [15:0] cw;
  logic [ADDR_W-1:0] list_start;
  assign list_start = {list_pointer_high, list_pointer_mid, list_pointer_low};
  assign cw = {f_data, ctrl_r[7:0]};
  // one byte at a time; the done cycle is skipped so a byte is never consumed twice
  assign f_start = (st_r == S_CW0 || st_r == S_CW1 || st_r == S_PARAM) && !f_busy && !f_done;
  list_byte_fetch u_fetch (
    .clk(clk),
    .rstn(rstn),
    .start(f_start),
    .abort(vsync_pulse),
    .addr(la_r),
    .busy(f_busy),
    .done(f_done),
    .data(f_data),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );
  always_comb
  begin
    st_nxt = st_r; ctrl_nxt = ctrl_r; la_nxt = la_r; grp_nxt = grp_r; bi_nxt = bi_r;
    rpt_nxt = rpt_r; trow_nxt = trow_r; mrow_nxt = mrow_r;
    otx_nxt = otx_r; opx_nxt = opx_r; hr_nxt = hr_r; lr_nxt = lr_r; map_nxt = map_r;
    op_nxt = op_r; os_nxt = os_r; mp_nxt = mp_r; ms_nxt = ms_r;
    ths_nxt = ths_r; tvs_nxt = tvs_r; fb_nxt = fb_r; pr_nxt = pr_r;
    mhs_nxt = mhs_r; mvs_nxt = mvs_r; fw_nxt = fw_r; fh_nxt = fh_r;
    sp_nxt = sp_r; bk_nxt = bk_r;
    if (vsync_pulse)
    begin
      // frame top: defaults, then restart from the start pointer if list_run_enable is set
      otx_nxt = 1'b0; opx_nxt = 1'b0; hr_nxt = 1'b0; lr_nxt = 1'b0;
      map_nxt = 1'b0;
      ths_nxt = 3'h0; tvs_nxt = 3'h0;
      mhs_nxt = 5'h00; mvs_nxt = 5'h00; fw_nxt = FIELD_RST; fh_nxt = FIELD_RST;
      sp_nxt = SPAN_RST; pr_nxt = PRIO_RST;
      bk_nxt = BANK_RST;
      rpt_nxt = 8'h00; trow_nxt = 3'h0; mrow_nxt = 5'h00;
      la_nxt = list_start;
      st_nxt = list_run_enable ? S_CW0 : S_IDLE;
    end
    else
    begin
      case (st_r)
        S_CW0:
          if (f_done)
          begin
            ctrl_nxt[7:0] = f_data;
            la_nxt = la_r + 1'b1;
            st_nxt = S_CW1;
          end
        S_CW1:
          if (f_done)
          begin
            ctrl_nxt = cw;
            la_nxt = la_r + 1'b1;
            if (cw[B_TEXT] || cw[B_PIXEL] || cw[B_OFF])
            begin
              otx_nxt = cw[B_TEXT] && !cw[B_PIXEL] && !cw[B_OFF];
              opx_nxt = cw[B_PIXEL] && !cw[B_TEXT] && !cw[B_OFF];
            end
            // both resolution bits at once is forbidden; it falls back to standard
            if (cw[B_PIXEL] && !cw[B_TEXT] && !cw[B_OFF])
            begin
              hr_nxt = cw[B_HIRES] && !cw[B_LORES];
              lr_nxt = cw[B_LORES] && !cw[B_HIRES];
            end
            if (cw[B_MAP_OFF])
              map_nxt = 1'b0;
            else if (cw[B_MAP_ON])
              map_nxt = 1'b1;
            grp_nxt = next_grp(cw, 4'h0);
            bi_nxt = 3'h0;
            st_nxt = (next_grp(cw, 4'h0) == GRP_NONE) ? S_READY : S_PARAM;
          end
        S_PARAM:
          if (f_done)
          begin
            la_nxt = la_r + 1'b1;
            case (grp_r)
              GRP_REPEAT: rpt_nxt = f_data;
              GRP_OV_PTR:
              begin
                trow_nxt = 3'h0;
                case (bi_r)
                  3'h0: op_nxt[7:0] = f_data;
                  3'h1: op_nxt[15:8] = f_data;
                  3'h2: op_nxt[18:16] = f_data[2:0];
                  3'h3: os_nxt[7:0] = f_data;
                  default: os_nxt[11:8] = f_data[3:0];
                endcase
              end
              GRP_TSCROLL:
                if (bi_r == 3'h0)
                  ths_nxt = f_data[2:0];
                else
                  tvs_nxt = f_data[2:0];
              GRP_FONT: fb_nxt = f_data;
              GRP_MAP_PTR:
              begin
                mrow_nxt = 5'h00;
                case (bi_r)
                  3'h0: mp_nxt[7:0] = f_data;
                  3'h1: mp_nxt[15:8] = f_data;
                  3'h2: mp_nxt[18:16] = f_data[2:0];
                  3'h3: ms_nxt[7:0] = f_data;
                  default: ms_nxt[11:8] = f_data[3:0];
                endcase
              end
              GRP_MAP_PAR:
                case (bi_r)
                  3'h0: mhs_nxt = f_data[4:0];
                  3'h1: mvs_nxt = f_data[4:0];
                  3'h2: fw_nxt = f_data[4:0];
                  default: fh_nxt = f_data[4:0];
                endcase
              default:
                if (bi_r == 3'h0)
                begin
                  sp_nxt = f_data[SPAN_LSB +: 2];
                  bk_nxt = f_data[BANK_LSB +: 4];
                end
                else
                  pr_nxt = f_data;
            endcase
            bi_nxt = (bi_r == grp_len(grp_r) - 3'h1) ? 3'h0 : bi_r + 3'h1;
            if (bi_r == grp_len(grp_r) - 3'h1)
            begin
              grp_nxt = next_grp(ctrl_r, {1'b0, grp_r} + 4'h1);
              if (next_grp(ctrl_r, {1'b0, grp_r} + 4'h1) == GRP_NONE)
                st_nxt = S_READY;
            end
          end
        S_READY:
          if (line_end)
          begin
            if (opx_r || (otx_r && trow_r == TEXT_ROW_LAST))
              op_nxt = op_r + ADDR_W'(os_r);
            if (otx_r)
              trow_nxt = trow_r + 3'h1;
            mrow_nxt = (mrow_r >= fh_r) ? 5'h00 : mrow_r + 5'h01;
            if (mrow_r >= fh_r)
              mp_nxt = mp_r + ADDR_W'(ms_r);
            if (rpt_r != 8'h00)
              rpt_nxt = rpt_r - 8'h01;
            else
              st_nxt = ctrl_r[B_TERM] ? S_VWAIT : S_CW0;
          end
        default: st_nxt = st_r;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= S_IDLE; ctrl_r <= 16'h0000; la_r <= '0; grp_r <= GRP_NONE; bi_r <= 3'h0;
      rpt_r <= 8'h00; trow_r <= 3'h0; mrow_r <= 5'h00;
      otx_r <= 1'b0; opx_r <= 1'b0; hr_r <= 1'b0; lr_r <= 1'b0; map_r <= 1'b0;
      op_r <= '0; os_r <= '0; mp_r <= '0; ms_r <= '0;
      ths_r <= 3'h0; tvs_r <= 3'h0; fb_r <= 8'h00; pr_r <= PRIO_RST;
      mhs_r <= 5'h00; mvs_r <= 5'h00; fw_r <= FIELD_RST; fh_r <= FIELD_RST;
      sp_r <= SPAN_RST; bk_r <= BANK_RST;
    end
    else
    begin
      st_r <= st_nxt; ctrl_r <= ctrl_nxt; la_r <= la_nxt; grp_r <= grp_nxt; bi_r <= bi_nxt;
      rpt_r <= rpt_nxt; trow_r <= trow_nxt; mrow_r <= mrow_nxt;
      otx_r <= otx_nxt; opx_r <= opx_nxt; hr_r <= hr_nxt; lr_r <= lr_nxt; map_r <= map_nxt;
      op_r <= op_nxt; os_r <= os_nxt; mp_r <= mp_nxt; ms_r <= ms_nxt;
      ths_r <= ths_nxt; tvs_r <= tvs_nxt; fb_r <= fb_nxt; pr_r <= pr_nxt;
      mhs_r <= mhs_nxt; mvs_r <= mvs_nxt; fw_r <= fw_nxt; fh_r <= fh_nxt;
      sp_r <= sp_nxt; bk_r <= bk_nxt;
    end
  end
  assign line_ready = st_r[4];
  assign overlay_text = otx_r;
  assign overlay_pixel = opx_r;
  assign high_res = hr_r;
  assign low_res = lr_r;
  assign map_on = map_r;
  assign overlay_memory_pointer = op_r;
  assign overlay_line_stride = os_r;
  assign text_hscroll = ths_r;
  assign text_vscroll = tvs_r;
  assign font_base = fb_r;
  assign attribute_map_pointer = mp_r;
  assign attribute_map_stride = ms_r;
  assign map_hscroll = mhs_r;
  assign map_vscroll = mvs_r;
  assign field_width = fw_r;
  assign field_height = fh_r;
  assign display_span_select = sp_r;
  assign palette_bank_offset = bk_r;
  // the map overrides this byte downstream, so it is still loaded while the map is on
  assign main_priority = pr_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_run_gate;
    vsync_pulse && !list_run_enable |=> (st_r == S_IDLE && !mem_req) [*3];
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("list ran while disabled");
  property p_start_addr;
    vsync_pulse && list_run_enable |=> la_r == $past(list_start) && st_r == S_CW0;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("bad restart");
  property p_frame_modes;
    vsync_pulse |=> !otx_r && !opx_r && !map_r && ths_r == 3'h0 && tvs_r == 3'h0;
  endproperty
  a_frame_modes: assert property (p_frame_modes) else $error("frame defaults");
  property p_frame_map;
    vsync_pulse |=> fw_r == 5'h07 && fh_r == 5'h07 && sp_r == 2'h1 && pr_r == 8'hff;
  endproperty
  a_frame_map: assert property (p_frame_map) else $error("map defaults");
  property p_overlay_conflict;
    st_r == S_CW1 && f_done && ctrl_r[B_TEXT] && ctrl_r[B_PIXEL] |=> !otx_r && !opx_r;
  endproperty
  a_overlay_conflict: assert property (p_overlay_conflict) else $error("conflict");
  property p_repeat;
    st_r == S_READY && line_end && !vsync_pulse && rpt_r != 8'h00
      |=> st_r == S_READY && rpt_r == $past(rpt_r) - 8'h01 && !mem_req;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat count");
  property p_terminator;
    st_r == S_READY && line_end && !vsync_pulse && rpt_r == 8'h00 && ctrl_r[B_TERM]
      |=> st_r == S_VWAIT ##1 (st_r == S_VWAIT || $past(vsync_pulse));
  endproperty
  a_terminator: assert property (p_terminator) else $error("no end wait");
  property p_pixel_stride;
    st_r == S_READY && line_end && !vsync_pulse && opx_r
      |=> op_r == $past(op_r) + ADDR_W'($past(os_r));
  endproperty
  a_pixel_stride: assert property (p_pixel_stride) else $error("pixel stride");
  property p_ready_holds;
    st_r == S_READY && !line_end && !vsync_pulse |=> st_r == S_READY && !mem_req;
  endproperty
  a_ready_holds: assert property (p_ready_holds) else $error("left ready early");
endmodule

// ---- list_memory_model.sv ----
`timescale 1ns/1ps
module list_memory_model
  import line_list_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // video memory read port
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] bytes [logic [ADDR_W-1:0]];
  int wait_cycles = 0;
  int cnt;
  logic [7:0] last_r;
  // between acks the data line shows the inverse of the last byte, never a stale copy
  always @*
  begin
    mem_ack = mem_req && (cnt == wait_cycles);
    mem_rdata = ~last_r;
    if (mem_ack)
      mem_rdata = bytes.exists(mem_addr) ? bytes[mem_addr] : 8'h00;
  end
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 0;
      last_r <= 8'h00;
    end
    else
    begin
      cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
      if (mem_ack)
        last_r <= mem_rdata;
    end
  end
endmodule

// ---- line_list_ctrl_test.sv ----
`timescale 1ns/1ps
module line_list_ctrl_test;
  import line_list_pkg::*;
  localparam logic [18:0] S = 19'h7ffe0;
  logic clk, rstn, list_run_enable, vsync_pulse, line_end;
  logic [7:0] list_pointer_low, list_pointer_mid;
  logic [2:0] list_pointer_high;
  logic mem_req, mem_ack, line_ready, overlay_text, overlay_pixel, high_res, low_res, map_on;
  logic [ADDR_W-1:0] mem_addr, overlay_memory_pointer, attribute_map_pointer;
  logic [7:0] mem_rdata, font_base, main_priority;
  logic [STRIDE_W-1:0] overlay_line_stride, attribute_map_stride;
  logic [2:0] text_hscroll, text_vscroll;
  logic [4:0] map_hscroll, map_vscroll, field_width, field_height;
  logic [1:0] display_span_select;
  logic [3:0] palette_bank_offset;
  int n_mismatch = 0;
  int num_checks = 0;

  line_list_ctrl u_line_list_ctrl (.clk(clk), .rstn(rstn), .list_run_enable(list_run_enable),
    .list_pointer_low(list_pointer_low), .list_pointer_mid(list_pointer_mid),
    .list_pointer_high(list_pointer_high), .vsync_pulse(vsync_pulse), .line_end(line_end),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .line_ready(line_ready), .overlay_text(overlay_text), .overlay_pixel(overlay_pixel),
    .high_res(high_res), .low_res(low_res), .map_on(map_on),
    .overlay_memory_pointer(overlay_memory_pointer), .overlay_line_stride(overlay_line_stride),
    .text_hscroll(text_hscroll), .text_vscroll(text_vscroll), .font_base(font_base),
    .attribute_map_pointer(attribute_map_pointer), .attribute_map_stride(attribute_map_stride),
    .map_hscroll(map_hscroll), .map_vscroll(map_vscroll), .field_width(field_width),
    .field_height(field_height), .display_span_select(display_span_select),
    .palette_bank_offset(palette_bank_offset), .main_priority(main_priority));
  list_memory_model u_list_memory_model (.clk(clk), .rstn(rstn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #4 clk = ~clk;

  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic put(input logic [18:0] a, input logic [7:0] d[$]);
    foreach (d[i])
      u_list_memory_model.bytes[19'(a + i)] = d[i];
  endtask

  task automatic pulse_vsync;
    vsync_pulse = 1'b1;
    @(negedge clk);
    vsync_pulse = 1'b0;
  endtask

  task automatic pulse_line;
    line_end = 1'b1;
    @(negedge clk);
    line_end = 1'b0;
  endtask

  task automatic wait_ready;
    for (int i = 0; i < 300 && line_ready !== 1'b1; i++)
      @(negedge clk);
    chk("line_ready", 1, line_ready);
    if (line_ready !== 1'b1)
      final_report;
  endtask

  task automatic t_reset_defaults;
    chk("line_ready", 0, line_ready);
    chk("mem_req", 0, mem_req);
    chk("overlay_text", 0, overlay_text);
    chk("overlay_pixel", 0, overlay_pixel);
    chk("map_on", 0, map_on);
    chk("text_hscroll", 0, text_hscroll);
    chk("text_vscroll", 0, text_vscroll);
    chk("map_hscroll", 0, map_hscroll);
    chk("field_width", 7, field_width);
    chk("field_height", 7, field_height);
    chk("display_span_select", 1, display_span_select);
    chk("palette_bank_offset", 0, palette_bank_offset);
    chk("main_priority", 8'hff, main_priority);
  endtask

  task automatic t_disabled;
    int seen;
    list_run_enable = 1'b0;
    pulse_vsync;
    seen = 0;
    repeat (50)
    begin
      @(negedge clk);
      seen |= (mem_req !== 1'b0);
    end
    chk("mem_req idle", 0, seen);
  endtask

  // record one uses every parameter group, 20 bytes, through a slow memory
  task automatic t_full_record;
    int seen;
    put(S, '{8'he9, 8'h0f, 8'h07, 8'h56, 8'h34, 8'h05, 8'h21, 8'h0a, 8'h03, 8'h05, 8'h9a,
      8'h11, 8'h22, 8'h06, 8'hff, 8'h0f, 8'h1f, 8'h02, 8'h0f, 8'h03, 8'h92, 8'h5a});
    put(19'(S + 22), '{8'h1b, 8'h90});
    u_list_memory_model.wait_cycles = 3;
    list_run_enable = 1'b1;
    pulse_vsync;
    wait_ready;
    chk("overlay_text", 1, overlay_text);
    chk("map_on", 1, map_on);
    chk("overlay_memory_pointer", 19'h53456, overlay_memory_pointer);
    chk("overlay_line_stride", 12'ha21, overlay_line_stride);
    chk("text_hscroll", 3, text_hscroll);
    chk("text_vscroll", 5, text_vscroll);
    chk("font_base", 8'h9a, font_base);
    chk("attribute_map_pointer", 19'h62211, attribute_map_pointer);
    chk("attribute_map_stride", 12'hfff, attribute_map_stride);
    chk("map_hscroll", 5'h1f, map_hscroll);
    chk("map_vscroll", 2, map_vscroll);
    chk("field_width", 5'h0f, field_width);
    chk("field_height", 3, field_height);
    chk("display_span_select", 2, display_span_select);
    chk("palette_bank_offset", 9, palette_bank_offset);
    chk("main_priority", 8'h5a, main_priority);
    for (int i = 1; i <= 8; i++)
    begin
      pulse_line;
      if (i < 8)
        chk("mem_req repeat", 0, mem_req);
      chk("attribute_map_pointer", 19'(19'h62211 + (i / 4) * 12'hfff), attribute_map_pointer);
      chk("overlay_memory_pointer", 19'(19'h53456 + (i / 8) * 12'ha21), overlay_memory_pointer);
    end
    wait_ready;
    chk("overlay_text", 0, overlay_text);
    chk("overlay_pixel", 0, overlay_pixel);
    chk("map_on", 0, map_on);
    chk("high_res", 0, high_res);
    chk("text_hscroll", 3, text_hscroll);
    pulse_line;
    chk("line_ready end", 0, line_ready);
    seen = 0;
    repeat (40)
    begin
      @(negedge clk);
      seen |= (mem_req !== 1'b0);
    end
    chk("mem_req after end", 0, seen);
  endtask

  // vsync restarts from the list start with frame-top values, prompt memory
  task automatic t_restart;
    int i;
    put(S, '{8'h42, 8'h20, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h02, 8'h90});
    u_list_memory_model.wait_cycles = 0;
    pulse_vsync;
    chk("text_hscroll", 0, text_hscroll);
    chk("field_width", 7, field_width);
    chk("map_on", 0, map_on);
    for (i = 0; i < 20 && mem_req !== 1'b1; i++)
      @(negedge clk);
    chk("restart mem_req", 1, mem_req);
    chk("restart mem_addr", S, mem_addr);
    if (mem_req !== 1'b1)
      final_report;
    wait_ready;
    chk("overlay_pixel", 1, overlay_pixel);
    chk("low_res", 1, low_res);
    chk("high_res", 0, high_res);
    chk("overlay_memory_pointer", 0, overlay_memory_pointer);
    pulse_line;
    chk("overlay_memory_pointer", 19'h00040, overlay_memory_pointer);
    wait_ready;
    chk("overlay_pixel", 1, overlay_pixel);
    chk("high_res", 1, high_res);
    chk("low_res", 0, low_res);
    chk("overlay_memory_pointer", 19'h00040, overlay_memory_pointer);
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    list_run_enable = 1'b0;
    vsync_pulse = 1'b0;
    line_end = 1'b0;
    list_pointer_low = 8'he0;
    list_pointer_mid = 8'hff;
    list_pointer_high = 3'h7;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset_defaults;
    t_disabled;
    t_full_record;
    t_restart;
    t_disabled;
    final_report;
  end
endmodule
